/* File: core/level_debouncer.sv */
// stable-level debouncer with selectable period
`timescale 1ns/1ps
module level_debouncer
	import onkey_supply_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// control
	input  wire logic             rst_level,
	input  wire logic [CNT_W-1:0] period,
	// data
	input  wire logic             raw_in,
	output logic                  clean_ff,
	output logic                  busy_ff
);

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic             nxt_clean;
	logic             nxt_busy;

	always_comb
	begin
		nxt_cnt   = '0;
		nxt_clean = clean_ff;
		nxt_busy  = 1'b0;
		if (raw_in != clean_ff)
		begin
			nxt_busy = 1'b1;
			if (cnt_ff + 1'b1 >= period)
			begin
				nxt_clean = raw_in;
				nxt_busy  = 1'b0;
			end
			else
				nxt_cnt = cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			cnt_ff   <= '0;
			clean_ff <= rst_level;
			busy_ff  <= 1'b0;
		end
		else
		begin
			cnt_ff   <= nxt_cnt;
			clean_ff <= nxt_clean;
			busy_ff  <= nxt_busy;
		end
	end

endmodule : level_debouncer

/* File: core/onkey_supply_pkg.sv */
// constants, register map and state types for the on-key supply supervisor
package onkey_supply_pkg;

	localparam int unsigned CLK_MHZ          = 200;
	localparam int unsigned DBNC_SHORT_US    = 100;
	localparam int unsigned DBNC_LONG_MS     = 30;
	localparam int unsigned HOLD_SHORT_S     = 8;
	localparam int unsigned HOLD_LONG_S      = 16;
	localparam int unsigned CHG_DBNC_MS      = 120;
	localparam int unsigned POR_SETTLE_NS    = 1000;
	localparam int unsigned CLK_NS           = 1000 / CLK_MHZ;

	localparam int unsigned DBNC_SHORT_CYC   = DBNC_SHORT_US * CLK_MHZ;
	localparam int unsigned DBNC_LONG_CYC    = DBNC_LONG_MS * 1000 * CLK_MHZ;
	localparam int unsigned HOLD_SHORT_CYC   = HOLD_SHORT_S * 1000 * 1000 * CLK_MHZ;
	localparam int unsigned HOLD_LONG_CYC    = HOLD_LONG_S * 1000 * 1000 * CLK_MHZ;
	localparam int unsigned CHG_DBNC_CYC     = CHG_DBNC_MS * 1000 * CLK_MHZ;
	localparam int unsigned POR_SETTLE_CYC   = (POR_SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SEQ_CYC          = 16;

	localparam int unsigned CNT_W            = 32;
	localparam int unsigned AW               = 4;
	localparam int unsigned DW               = 8;

	localparam logic [AW-1:0] ADDR_CONFIG    = 4'h0;
	localparam logic [AW-1:0] ADDR_IRQ_FLAGS = 4'h1;
	localparam logic [AW-1:0] ADDR_IRQ_MASK  = 4'h2;
	localparam logic [AW-1:0] ADDR_STATUS    = 4'h3;

	// config bits
	localparam int unsigned CFG_SWITCH_TYPE  = 0;
	localparam int unsigned CFG_DBNC_SEL     = 1;
	localparam int unsigned CFG_HOLD_SEL     = 2;
	// irq flag / mask bits
	localparam int unsigned IRQ_RISE         = 0;
	localparam int unsigned IRQ_FALL         = 1;
	localparam int unsigned IRQ_CHG          = 2;
	localparam int unsigned IRQ_THERM        = 3;
	localparam int unsigned IRQ_N            = 4;

	localparam logic [DW-1:0] CONFIG_RST     = 8'h00;
	localparam logic [IRQ_N-1:0] MASK_RST    = 4'hF;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_STANDBY,
		ST_CHECK,
		ST_POWER_UP,
		ST_ON,
		ST_POWER_DOWN
	} ctl_state_e;

endpackage : onkey_supply_pkg

/* File: core/onkey_supply_supervisor.sv */
// on/off controller, supply lockouts, on-key debounce, long hold and interrupts
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module onkey_supply_supervisor
	import onkey_supply_pkg::*;
(
	// clock and reset
	input  wire logic          clk,
	input  wire logic          nrst,
	// supply and thermal monitors
	input  wire logic          supply_por_reset,
	input  wire logic          supply_undervoltage_flag,
	input  wire logic          supply_overvoltage_flag,
	input  wire logic          thermal_shutdown,
	input  wire logic          charger_present,
	// on-key
	input  wire logic          onkey_in_n,
	// register port
	input  wire logic [AW-1:0] reg_addr,
	input  wire logic [DW-1:0] reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic [DW-1:0]      reg_rdata_ff,
	// regulator sequencer and monitors
	output logic               sys_reset_ff,
	output logic               uvlo_enable_ff,
	output logic               ovlo_enable_ff,
	output logic               regulators_on_ff,
	output logic               slow_osc_enable_ff,
	// interrupt pin, open drain
	output logic               irq_out_n_ff,
	output logic               irq_oe_ff
);

	// controller state
	ctl_state_e       state_ff;
	ctl_state_e       nxt_state;
	logic [CNT_W-1:0] tmr_ff;
	logic [CNT_W-1:0] nxt_tmr;
	logic [CNT_W-1:0] hold_ff;
	logic [CNT_W-1:0] nxt_hold;

	// registers
	logic [DW-1:0]    config_ff;
	logic [DW-1:0]    nxt_config;
	logic [IRQ_N-1:0] flags_ff;
	logic [IRQ_N-1:0] nxt_flags;
	logic [IRQ_N-1:0] mask_ff;
	logic [IRQ_N-1:0] nxt_mask;
	logic [DW-1:0]    nxt_rdata;

	// debounced inputs
	logic             onkey_db;
	logic             onkey_prev_ff;
	logic             onkey_busy;
	logic             chg_db;
	logic             chg_prev_ff;
	logic [CNT_W-1:0] onkey_period;
	logic [CNT_W-1:0] hold_period;
	logic             onkey_fall;
	logic             onkey_rise;
	logic             chg_rise;
	logic             hold_active;
	logic             hold_done;
	logic             in_standby;

	assign onkey_period = config_ff[CFG_DBNC_SEL] ? CNT_W'(DBNC_LONG_CYC)
	                                               : CNT_W'(DBNC_SHORT_CYC);
	assign hold_period  = config_ff[CFG_HOLD_SEL] ? CNT_W'(HOLD_LONG_CYC)
	                                               : CNT_W'(HOLD_SHORT_CYC);

	// on-key debounce, idle level high
	level_debouncer u_onkey_db (
		.clk      (clk),
		.nrst     (nrst),
		.rst_level(1'b1),
		.period   (onkey_period),
		.raw_in   (onkey_in_n),
		.clean_ff (onkey_db),
		.busy_ff  (onkey_busy)
	);

	// charger insertion debounce
	level_debouncer u_chg_db (
		.clk      (clk),
		.nrst     (nrst),
		.rst_level(1'b0),
		.period   (CNT_W'(CHG_DBNC_CYC)),
		.raw_in   (charger_present),
		.clean_ff (chg_db),
		.busy_ff  ()
	);

	assign onkey_fall = onkey_prev_ff & ~onkey_db;
	assign onkey_rise = ~onkey_prev_ff & onkey_db;
	assign chg_rise   = ~chg_prev_ff & chg_db;
	assign in_standby = (state_ff == ST_STANDBY) || (state_ff == ST_RESET);

	// long hold: low level for push-button, high level for slide switch
	assign hold_active = (state_ff == ST_ON)
	                   && (config_ff[CFG_SWITCH_TYPE] ? onkey_db : ~onkey_db);
	assign hold_done   = hold_active && (hold_ff + 1'b1 >= hold_period);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_tmr   = '0;
		nxt_hold  = hold_active ? hold_ff + 1'b1 : '0;
		case (state_ff)
			ST_RESET:
			begin
				// settle after supply crosses threshold
				if (tmr_ff + 1'b1 >= CNT_W'(POR_SETTLE_CYC))
					nxt_state = ST_STANDBY;
				else
					nxt_tmr = tmr_ff + 1'b1;
			end
			ST_STANDBY:
			begin
				if ((onkey_fall || chg_rise) && !thermal_shutdown)
					nxt_state = ST_CHECK;
			end
			ST_CHECK:
			begin
				// comparator enabled this cycle, sampled next
				if (tmr_ff == '0)
					nxt_tmr = tmr_ff + 1'b1;
				else if (supply_undervoltage_flag || supply_overvoltage_flag)
					nxt_state = ST_STANDBY;
				else
					nxt_state = ST_POWER_UP;
			end
			ST_POWER_UP:
			begin
				if (supply_undervoltage_flag || supply_overvoltage_flag || thermal_shutdown)
					nxt_state = ST_POWER_DOWN;
				else if (tmr_ff + 1'b1 >= CNT_W'(SEQ_CYC))
					nxt_state = ST_ON;
				else
					nxt_tmr = tmr_ff + 1'b1;
			end
			ST_ON:
			begin
				if (hold_done || supply_undervoltage_flag || supply_overvoltage_flag
				    || thermal_shutdown)
				begin
					nxt_state = ST_POWER_DOWN;
					nxt_hold  = '0;
				end
			end
			ST_POWER_DOWN:
			begin
				if (tmr_ff + 1'b1 >= CNT_W'(SEQ_CYC))
					nxt_state = ST_STANDBY;
				else
					nxt_tmr = tmr_ff + 1'b1;
			end
			default:
				nxt_state = ST_RESET;
		endcase
		if (supply_por_reset)
		begin
			nxt_state = ST_RESET;
			nxt_tmr   = '0;
			nxt_hold  = '0;
		end
	end

	// register writes and interrupt flags
	always_comb
	begin
		nxt_config = config_ff;
		nxt_mask   = mask_ff;
		nxt_flags  = flags_ff;
		nxt_rdata  = '0;
		if (reg_wr && reg_addr == ADDR_CONFIG)
			nxt_config = reg_wdata;
		if (reg_wr && reg_addr == ADDR_IRQ_MASK)
			nxt_mask = reg_wdata[IRQ_N-1:0];
		if (reg_wr && reg_addr == ADDR_IRQ_FLAGS)
			nxt_flags = flags_ff & ~reg_wdata[IRQ_N-1:0];
		// set wins over write-one-to-clear
		if (onkey_rise)
			nxt_flags[IRQ_RISE] = 1'b1;
		if (onkey_fall)
			nxt_flags[IRQ_FALL] = 1'b1;
		if (chg_rise)
			nxt_flags[IRQ_CHG] = 1'b1;
		if (thermal_shutdown)
			nxt_flags[IRQ_THERM] = 1'b1;
		if (reg_rd)
		begin
			case (reg_addr)
				ADDR_CONFIG:    nxt_rdata = config_ff;
				ADDR_IRQ_FLAGS: nxt_rdata = DW'(flags_ff);
				ADDR_IRQ_MASK:  nxt_rdata = DW'(mask_ff);
				ADDR_STATUS:    nxt_rdata = {DW'(state_ff)} | {onkey_db, chg_db, 6'h00};
				default:        nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state_ff           <= ST_RESET;
			tmr_ff             <= '0;
			hold_ff            <= '0;
			config_ff          <= CONFIG_RST;
			mask_ff            <= MASK_RST;
			flags_ff           <= '0;
			reg_rdata_ff       <= '0;
			onkey_prev_ff      <= 1'b1;
			chg_prev_ff        <= 1'b0;
			sys_reset_ff       <= 1'b1;
			uvlo_enable_ff     <= 1'b0;
			ovlo_enable_ff     <= 1'b0;
			regulators_on_ff   <= 1'b0;
			slow_osc_enable_ff <= 1'b0;
			irq_out_n_ff       <= 1'b1;
			irq_oe_ff          <= 1'b0;
		end
		else
		begin
			state_ff           <= nxt_state;
			tmr_ff             <= nxt_tmr;
			hold_ff            <= nxt_hold;
			config_ff          <= nxt_config;
			mask_ff            <= nxt_mask;
			flags_ff           <= nxt_flags;
			reg_rdata_ff       <= nxt_rdata;
			onkey_prev_ff      <= onkey_db;
			chg_prev_ff        <= chg_db;
			sys_reset_ff       <= (nxt_state == ST_RESET);
			uvlo_enable_ff     <= (nxt_state != ST_STANDBY) && (nxt_state != ST_RESET);
			ovlo_enable_ff     <= (nxt_state != ST_STANDBY) && (nxt_state != ST_RESET);
			regulators_on_ff   <= (nxt_state == ST_POWER_UP) || (nxt_state == ST_ON);
			slow_osc_enable_ff <= (onkey_busy && config_ff[CFG_DBNC_SEL]) || hold_active;
			irq_out_n_ff       <= 1'b0;
			irq_oe_ff          <= |(nxt_flags & ~nxt_mask);
		end
	end

	// checks
	property p_reset_in_por;
		@(posedge clk) disable iff (!nrst)
		supply_por_reset |=> sys_reset_ff;
	endproperty
	a_reset_in_por: assert property (p_reset_in_por) else $error("reset not held");

	property p_uvlo_off_standby;
		@(posedge clk) disable iff (!nrst)
		in_standby |-> !uvlo_enable_ff;
	endproperty
	a_uvlo_off_standby: assert property (p_uvlo_off_standby) else $error("uvlo on in standby");

	property p_ovlo_off_standby;
		@(posedge clk) disable iff (!nrst)
		(state_ff == ST_STANDBY) && $past(state_ff == ST_STANDBY) |-> !ovlo_enable_ff;
	endproperty
	a_ovlo_off_standby: assert property (p_ovlo_off_standby) else $error("ovlo on in standby");

	property p_uv_back;
		@(posedge clk) disable iff (!nrst)
		(state_ff == ST_CHECK) && tmr_ff != '0 && supply_undervoltage_flag && !supply_por_reset
		|=> state_ff == ST_STANDBY;
	endproperty
	a_uv_back: assert property (p_uv_back) else $error("undervoltage not rejected");

	property p_ov_inhibit;
		@(posedge clk) disable iff (!nrst)
		(state_ff == ST_ON) && supply_overvoltage_flag && !supply_por_reset
		|=> state_ff == ST_POWER_DOWN;
	endproperty
	a_ov_inhibit: assert property (p_ov_inhibit) else $error("overvoltage ignored");

	property p_fall_wake;
		@(posedge clk) disable iff (!nrst)
		(state_ff == ST_STANDBY) && onkey_fall && !thermal_shutdown && !supply_por_reset
		|=> state_ff == ST_CHECK;
	endproperty
	a_fall_wake: assert property (p_fall_wake) else $error("falling edge no wake");

	property p_fall_flag;
		@(posedge clk) disable iff (!nrst)
		onkey_fall |=> flags_ff[IRQ_FALL] ##1 flags_ff[IRQ_FALL] || $past(reg_wr);
	endproperty
	a_fall_flag: assert property (p_fall_flag) else $error("fall flag missing");

	property p_hold_only_on;
		@(posedge clk) disable iff (!nrst)
		state_ff != ST_ON |-> hold_ff == '0 || $past(state_ff) == ST_ON;
	endproperty
	a_hold_only_on: assert property (p_hold_only_on) else $error("hold counts off state");

	property p_irq_masked;
		@(posedge clk) disable iff (!nrst)
		irq_oe_ff |-> $past(|(flags_ff & ~mask_ff)) || |(flags_ff & ~mask_ff);
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked irq drives pin");

	property p_therm_down;
		@(posedge clk) disable iff (!nrst)
		(state_ff == ST_ON) && thermal_shutdown && !supply_por_reset |=> state_ff == ST_POWER_DOWN;
	endproperty
	a_therm_down: assert property (p_therm_down) else $error("thermal ignored");

endmodule : onkey_supply_supervisor

/* File: dv/onkey_switch_host_model.sv */
// on-key switch with contact chatter and pulled-up host interrupt input
`timescale 1ns/1ps
module onkey_switch_host_model
(
	// clock
	input  wire logic clk,
	// switch lever and contact
	input  wire logic pressed,
	output logic      onkey_in_n,
	// interrupt pin
	input  wire logic irq_out_n_ff,
	input  wire logic irq_oe_ff,
	output logic      irq_line
);
	logic       lvl_ff = 1'b1;
	logic       pin_ff = 1'b1;
	logic [3:0] bnc_ff = 4'h0;

	// contact chatters for some cycles after every lever move
	always_ff @(posedge clk)
	begin
		if (lvl_ff == pressed)
		begin
			lvl_ff <= ~pressed;
			bnc_ff <= 4'h9;
		end
		else if (bnc_ff != 4'h0)
			bnc_ff <= bnc_ff - 4'h1;
		pin_ff <= (bnc_ff > 4'h1) ? ~pin_ff : lvl_ff;
	end

	assign onkey_in_n = pin_ff;
	// host pull-up holds the line high unless the pin pulls it low
	assign irq_line = irq_oe_ff ? irq_out_n_ff : 1'b1;
endmodule : onkey_switch_host_model

/* File: dv/tb_onkey_supply_supervisor.sv */
// self-checking bench for the on-key supply supervisor
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_onkey_supply_supervisor
	import onkey_supply_pkg::*;
;
	logic          clk, nrst, por, uv, ov, therm, chg, key_n, pressed, irq_line;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata, rdata, d;
	logic          wr, rd, sys_rst, uv_en, ov_en, reg_on, osc_en, irq_n, irq_oe;
	int            error_cnt, tests_run, c, n, s0, cnt_uv, cnt_reg, cnt_osc;

	onkey_supply_supervisor dut_u (.clk(clk), .nrst(nrst), .supply_por_reset(por),
		.supply_undervoltage_flag(uv), .supply_overvoltage_flag(ov),
		.thermal_shutdown(therm), .charger_present(chg), .onkey_in_n(key_n),
		.reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata_ff(rdata), .sys_reset_ff(sys_rst), .uvlo_enable_ff(uv_en),
		.ovlo_enable_ff(ov_en), .regulators_on_ff(reg_on),
		.slow_osc_enable_ff(osc_en), .irq_out_n_ff(irq_n), .irq_oe_ff(irq_oe));

	onkey_switch_host_model partner_u (.clk(clk), .pressed(pressed), .onkey_in_n(key_n),
		.irq_out_n_ff(irq_n), .irq_oe_ff(irq_oe), .irq_line(irq_line));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// cycle counts of enables, for windows longer than one poll
	always @(posedge clk)
	begin
		cnt_uv  <= cnt_uv + int'(uv_en === 1'b1);
		cnt_reg <= cnt_reg + int'(reg_on === 1'b1);
		cnt_osc <= cnt_osc + int'(osc_en === 1'b1);
	end

	task automatic summarize;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] v);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : wr_reg

	task automatic rd_reg(input logic [AW-1:0] a);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask : rd_reg

	// poll status until masked bits match, cycles spent left in c
	task automatic wait_st(input logic [DW-1:0] m, input logic [DW-1:0] v, input int lim);
		c = 0;
		rd_reg(ADDR_STATUS);
		while ((d & m) !== v)
		begin
			c += 2;
			if (c > lim)
			begin
				error_cnt++;
				$display("unexpected timeout on status %h", v);
				summarize();
			end
			rd_reg(ADDR_STATUS);
		end
	endtask : wait_st

	initial
	begin
		nrst = 1'b0;
		por = 1'b1;
		uv = 1'b0;
		ov = 1'b0;
		therm = 1'b0;
		chg = 1'b0;
		pressed = 1'b0;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (300) @(posedge clk);
		`CHK("reset_held", 1'b1, sys_rst)
		por <= 1'b0;
		n = 0;
		while (sys_rst !== 1'b0 && n < 1000)
		begin
			@(posedge clk);
			n++;
		end
		`CHK("reset_settle", 1'b1, n >= POR_SETTLE_CYC && n <= POR_SETTLE_CYC + 4)
		wait_st(8'hC7, {1'b1, 1'b0, 3'h0, ST_STANDBY}, 60);
		`CHK("standby_off", 3'h0, {uv_en, ov_en, reg_on})
		`CHK("pin_value", 1'b0, irq_n)
		rd_reg(ADDR_CONFIG);
		`CHK("config_reset", CONFIG_RST, d)
		rd_reg(ADDR_IRQ_MASK);
		`CHK("mask_reset", MASK_RST, d[IRQ_N-1:0])
		wr_reg(ADDR_CONFIG, 8'h05);
		wr_reg(4'hF, 8'hFF);
		rd_reg(4'hF);
		`CHK("unmapped_read", 8'h00, d)
		rd_reg(ADDR_CONFIG);
		`CHK("config_rw", 8'h05, d)
		wr_reg(ADDR_CONFIG, CONFIG_RST);
		// short press glitch with undervoltage shown in standby
		uv <= 1'b1;
		pressed <= 1'b1;
		repeat (100) @(posedge clk);
		pressed <= 1'b0;
		repeat (100) @(posedge clk);
		rd_reg(ADDR_STATUS);
		`CHK("glitch_ignored", {1'b1, 1'b0, 3'h0, ST_STANDBY}, d & 8'hC7)
		s0 = cnt_uv;
		pressed <= 1'b1;
		wait_st(8'h80, 8'h00, DBNC_SHORT_CYC + 100);
		`CHK("debounce_len", 1'b1, c >= DBNC_SHORT_CYC)
		repeat (10) @(posedge clk);
		rd_reg(ADDR_STATUS);
		`CHK("uv_back_standby", {5'h0, ST_STANDBY}, d & 8'h07)
		`CHK("uv_checked", 1'b1, cnt_uv > s0)
		`CHK("no_power_up", 0, cnt_reg)
		rd_reg(ADDR_IRQ_FLAGS);
		`CHK("fall_flag", 8'h02, d & 8'h03)
		`CHK("fall_masked", 1'b0, irq_oe)
		wr_reg(ADDR_IRQ_MASK, 8'h0D);
		`CHK("fall_pin", 2'b10, {irq_oe, irq_line})
		wr_reg(ADDR_IRQ_FLAGS, 8'h02);
		`CHK("fall_clear", 2'b01, {irq_oe, irq_line})
		pressed <= 1'b0;
		wait_st(8'h80, 8'h80, DBNC_SHORT_CYC + 100);
		rd_reg(ADDR_IRQ_FLAGS);
		`CHK("rise_flag", 8'h01, d & 8'h03)
		`CHK("rise_masked", 1'b0, irq_oe)
		wr_reg(ADDR_IRQ_FLAGS, 8'h01);
		`CHK("osc_idle_short", 0, cnt_osc)
		// supply good: press powers up
		uv <= 1'b0;
		s0 = cnt_reg;
		pressed <= 1'b1;
		wait_st(8'h07, {5'h0, ST_ON}, DBNC_SHORT_CYC + 200);
		`CHK("seq_len", 1'b1, cnt_reg - s0 >= SEQ_CYC && cnt_reg - s0 <= SEQ_CYC + 8)
		`CHK("on_outputs", 4'hE, {reg_on, uv_en, ov_en, sys_rst})
		`CHK("fall_pin_on", 1'b1, irq_oe)
		repeat (10) @(posedge clk);
		`CHK("hold_osc", 1'b1, osc_en)
		// slide switch: pressed key is no long hold
		wr_reg(ADDR_CONFIG, 8'h01);
		`CHK("slide_hold_osc", 1'b0, osc_en)
		ov <= 1'b1;
		wait_st(8'h07, {5'h0, ST_STANDBY}, SEQ_CYC + 40);
		`CHK("ov_shutdown", 4'h0, {reg_on, uv_en, ov_en, osc_en})
		ov <= 1'b0;
		wr_reg(ADDR_IRQ_FLAGS, 8'hFF);
		therm <= 1'b1;
		repeat (5) @(posedge clk);
		rd_reg(ADDR_IRQ_FLAGS);
		`CHK("therm_flag", 8'h08, d & 8'h08)
		`CHK("therm_masked", 1'b0, irq_oe)
		wr_reg(ADDR_IRQ_MASK, 8'h07);
		`CHK("therm_pin", 2'b10, {irq_oe, irq_line})
		therm <= 1'b0;
		wr_reg(ADDR_IRQ_FLAGS, 8'h08);
		`CHK("therm_clear", 2'b01, {irq_oe, irq_line})
		// long debounce counting runs the slow oscillator
		wr_reg(ADDR_CONFIG, 8'h02);
		pressed <= 1'b0;
		repeat (20) @(posedge clk);
		`CHK("osc_long_dbnc", 1'b1, osc_en)
		summarize();
	end
endmodule : tb_onkey_supply_supervisor
